// ---- rtl/crsc_top.sv ----
// clock source select, oscillator control, cpu divider, stop mode and reset generation
`timescale 1ns/1ps
module crsc_top #(
	parameter int STAB_CYC = crsc_pkg::STAB_CYC_DEFAULT // stabilisation wait in cycles
) (
	input  wire logic               mclk,            // block clock, 10 MHz
	input  wire logic               rst,             // synchronous reset, active high
	input  wire crsc_pkg::crsc_bus_t bus,            // register port request
	output logic [7:0]              rdata,           // read data, cycle after read
	input  wire logic               external_reset_n,// reset pin, active low
	input  wire logic               low_voltage_reset_sel, // option bit: 1 low-voltage reset in use
	input  wire logic               low_voltage,     // detector: supply below threshold
	input  wire logic               wdt_overflow,    // basic timer overflow pulse
	input  wire logic               opcode_valid,    // cpu executes opcode this cycle
	input  wire logic [7:0]         opcode,          // executed opcode
	input  wire logic               ext_irq_wake,    // filtered external interrupt request
	input  wire logic [15:0]        option_addr,     // reset address from option bytes
	input  wire logic               option_addr_use, // use option address instead of default
	output logic                    main_osc_en,     // main oscillator run
	output logic                    sub_osc_en,      // sub oscillator run
	output logic                    ring_osc_en,     // ring oscillator run
	output logic                    wake_tmr_ring,   // wake timer uses ring oscillator
	output logic                    clk_sel_sub,     // system clock from sub oscillator
	output logic                    cpu_tick,        // cpu clock enable pulse
	output logic                    cpu_clk,         // divided cpu clock level
	output logic                    sys_reset,       // internal reset to core
	output logic                    cpu_halt,        // cpu and peripherals halted
	output logic                    int_disable,     // all interrupts disabled
	output logic                    wdt_enable,      // watchdog reset function enabled
	output logic [7:0]              port_input,      // ports 0-4 forced to input
	output logic                    pc_load,         // one-cycle pulse: load pc
	output logic [15:0]             pc_value,        // reset vector address
	output logic                    irq_service      // one-cycle pulse: service wake interrupt
);
	// ------------------------------------------------------------------
	// reset pin filter and synchroniser
	// ------------------------------------------------------------------
	logic       pin_s1;
	logic       pin_s2;
	logic [7:0] filt_cnt;
	logic       pin_low;
	logic       wdt_rst;
	logic       any_reset;

	// two flops first, the filter only ever sees the second
	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_s1 <= 1'b1;
			pin_s2 <= 1'b1;
		end else begin
			pin_s1 <= external_reset_n;
			pin_s2 <= pin_s1;
		end
	end

	// pin must stay low a whole filter interval before it counts
	always_ff @(posedge mclk) begin
		if (rst) begin
			filt_cnt <= 8'h00;
			pin_low  <= 1'b0;
		end else if (pin_s2) begin
			filt_cnt <= 8'h00;
			pin_low  <= 1'b0;
		end else if (filt_cnt >= 8'(crsc_pkg::FILT_CYC - 1)) begin
			pin_low <= 1'b1;
		end else begin
			filt_cnt <= filt_cnt + 8'h01;
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [7:0] oscillator_control;
	logic [7:0] system_clock_divider_control;
	logic [7:0] ring_osc_control;
	logic [7:0] stop_enable_key;
	logic [7:0] basic_timer_control;
	crsc_pkg::crsc_state_t state;
	logic       stop_go;

	// a chosen option keeps only one external source armed
	assign wdt_rst   = wdt_overflow && wdt_enable;
	assign any_reset = rst || (low_voltage_reset_sel ? low_voltage : pin_low) || wdt_rst;

	// interrupt wake keeps registers: only reset sources reload them
	always_ff @(posedge mclk) begin
		if (any_reset) begin
			oscillator_control           <= crsc_pkg::OSC_CTRL_RST;
			system_clock_divider_control <= crsc_pkg::CLK_DIV_RST;
			ring_osc_control             <= crsc_pkg::RING_OSC_RST;
			stop_enable_key              <= crsc_pkg::STOP_KEY_RST;
			basic_timer_control          <= crsc_pkg::BT_CTRL_RST;
		end else if (bus.wr) begin
			case (bus.addr)
				crsc_pkg::OFS_OSC_CTRL: oscillator_control <= bus.wdata & 8'h0d;
				crsc_pkg::OFS_CLK_DIV:  system_clock_divider_control <= bus.wdata & 8'h98;
				crsc_pkg::OFS_RING_OSC: ring_osc_control <= bus.wdata & 8'hc0;
				crsc_pkg::OFS_STOP_KEY: stop_enable_key <= bus.wdata;
				crsc_pkg::OFS_BT_CTRL:  basic_timer_control <= bus.wdata;
				default: ;
			endcase
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				crsc_pkg::OFS_OSC_CTRL: rdata <= oscillator_control;
				crsc_pkg::OFS_CLK_DIV:  rdata <= system_clock_divider_control;
				crsc_pkg::OFS_RING_OSC: rdata <= ring_osc_control;
				crsc_pkg::OFS_STOP_KEY: rdata <= stop_enable_key;
				crsc_pkg::OFS_BT_CTRL:  rdata <= basic_timer_control;
				crsc_pkg::OFS_STATUS:   rdata <= {4'h0, wdt_enable, cpu_halt, state};
				default:                rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// ------------------------------------------------------------------
	// oscillator and clock select outputs
	// ------------------------------------------------------------------
	// main runs only when not stopped by bit nor by stop mode
	always_ff @(posedge mclk) begin
		if (any_reset) begin
			main_osc_en   <= 1'b1;
			sub_osc_en    <= 1'b1;
			ring_osc_en   <= 1'b0;
			wake_tmr_ring <= 1'b0;
			clk_sel_sub   <= 1'b0;
		end else begin
			main_osc_en   <= !oscillator_control[crsc_pkg::OSC_MAIN_STOP_BIT]
				&& !(state == crsc_pkg::CRSC_STOP) && !stop_go;
			sub_osc_en    <= !oscillator_control[crsc_pkg::OSC_SUB_STOP_BIT];
			ring_osc_en   <= ring_osc_control[crsc_pkg::RING_RUN_BIT];
			wake_tmr_ring <= ring_osc_control[crsc_pkg::RING_SEL_BIT];
			clk_sel_sub   <= oscillator_control[crsc_pkg::OSC_SEL_BIT];
		end
	end

	// source choice is software's job (enable main before selecting it)
	logic src_running;
	assign src_running = (clk_sel_sub ? sub_osc_en : main_osc_en)
		&& (state != crsc_pkg::CRSC_STOP);

	crsc_clkdiv u_div (
		.mclk     (mclk),
		.rst      (any_reset),
		.run      (src_running),
		.div_sel  (system_clock_divider_control[crsc_pkg::DIV_HI_BIT:crsc_pkg::DIV_LO_BIT]),
		.cpu_tick (cpu_tick),
		.cpu_clk  (cpu_clk)
	);

	// ------------------------------------------------------------------
	// reset sequence and stop mode
	// ------------------------------------------------------------------
	localparam int SW = $clog2(STAB_CYC + 1);
	logic [SW-1:0] stab_cnt;
	logic          wake_irq;
	logic          wake_ok;

	assign stop_go = opcode_valid && (opcode == crsc_pkg::STOP_OPCODE)
		&& (stop_enable_key == crsc_pkg::STOP_KEY_VAL) && (state == crsc_pkg::CRSC_RUN);
	assign wake_ok = ext_irq_wake && system_clock_divider_control[crsc_pkg::WAKE_EN_BIT];

	always_ff @(posedge mclk) begin
		if (any_reset) begin
			state    <= crsc_pkg::CRSC_RESET;
			stab_cnt <= '0;
			wake_irq <= 1'b0;
		end else begin
			case (state)
				crsc_pkg::CRSC_RESET: begin
					state    <= crsc_pkg::CRSC_STABLE;
					stab_cnt <= '0;
				end
				crsc_pkg::CRSC_STABLE: begin
					if (stab_cnt >= SW'(STAB_CYC - 1)) begin
						state <= crsc_pkg::CRSC_RUN;
					end else begin
						stab_cnt <= stab_cnt + SW'(1);
					end
				end
				crsc_pkg::CRSC_RUN: begin
					wake_irq <= 1'b0;
					if (stop_go) begin
						state <= crsc_pkg::CRSC_STOP;
					end
				end
				crsc_pkg::CRSC_STOP: begin
					// wake waits a stabilisation interval, then serves the interrupt
					if (wake_ok) begin
						state    <= crsc_pkg::CRSC_STABLE;
						stab_cnt <= '0;
						wake_irq <= 1'b1;
					end
				end
				default: state <= crsc_pkg::CRSC_RESET;
			endcase
		end
	end

	// software is expected to set the interval before stop; this block uses a fixed count
	always_ff @(posedge mclk) begin
		if (any_reset) begin
			sys_reset   <= 1'b1;
			cpu_halt    <= 1'b1;
			int_disable <= 1'b1;
			wdt_enable  <= 1'b1;
			port_input  <= crsc_pkg::PORT_INPUT_ALL;
			pc_load     <= 1'b0;
			pc_value    <= crsc_pkg::RESET_ADDR;
			irq_service <= 1'b0;
		end else begin
			sys_reset   <= 1'b0;
			cpu_halt    <= (state != crsc_pkg::CRSC_RUN) || stop_go;
			pc_load     <= (state == crsc_pkg::CRSC_STABLE) && !wake_irq
				&& (stab_cnt >= SW'(STAB_CYC - 1));
			pc_value    <= option_addr_use ? option_addr : crsc_pkg::RESET_ADDR;
			irq_service <= (state == crsc_pkg::CRSC_STABLE) && wake_irq
				&& (stab_cnt >= SW'(STAB_CYC - 1));
			if (state == crsc_pkg::CRSC_RUN)
				int_disable <= 1'b0;
			if (basic_timer_control[7:4] == crsc_pkg::WDT_OFF_KEY)
				wdt_enable <= 1'b0;
			else
				wdt_enable <= 1'b1;
			port_input  <= crsc_pkg::PORT_INPUT_ALL;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	property p_key_stop;
		@(posedge mclk) disable iff (rst)
		(state == crsc_pkg::CRSC_RUN && stop_go && !any_reset) |=> (state == crsc_pkg::CRSC_STOP);
	endproperty
	a_key_stop: assert property (p_key_stop) else $error("keyed stop not entered");

	property p_no_key;
		@(posedge mclk) disable iff (rst)
		(opcode_valid && opcode == crsc_pkg::STOP_OPCODE && stop_enable_key != crsc_pkg::STOP_KEY_VAL
			&& state == crsc_pkg::CRSC_RUN && !any_reset) |=> (state == crsc_pkg::CRSC_RUN);
	endproperty
	a_no_key: assert property (p_no_key) else $error("stop taken without key");

	property p_main_stop;
		@(posedge mclk) disable iff (rst)
		(state == crsc_pkg::CRSC_STOP && !any_reset) |=> !main_osc_en;
	endproperty
	a_main_stop: assert property (p_main_stop) else $error("main runs in stop");

	property p_reset_div;
		@(posedge mclk) any_reset |=> (system_clock_divider_control[4:3] == 2'b00) && sys_reset;
	endproperty
	a_reset_div: assert property (p_reset_div) else $error("divider not cleared");

	property p_sel;
		@(posedge mclk) disable iff (any_reset)
		##1 (clk_sel_sub == $past(oscillator_control[crsc_pkg::OSC_SEL_BIT]));
	endproperty
	a_sel: assert property (p_sel) else $error("select not followed");

	property p_wdt_off;
		@(posedge mclk) disable iff (any_reset)
		(basic_timer_control[7:4] == crsc_pkg::WDT_OFF_KEY) |=> !wdt_enable;
	endproperty
	a_wdt_off: assert property (p_wdt_off) else $error("watchdog not disabled");

	property p_lv_hold;
		@(posedge mclk) (low_voltage_reset_sel && low_voltage) [*2] |-> sys_reset;
	endproperty
	a_lv_hold: assert property (p_lv_hold) else $error("low voltage not held");

	property p_ring;
		@(posedge mclk) disable iff (any_reset)
		##1 (ring_osc_en == $past(ring_osc_control[crsc_pkg::RING_RUN_BIT]));
	endproperty
	a_ring: assert property (p_ring) else $error("ring run mismatch");

	property p_pin_filter;
		@(posedge mclk) disable iff (rst)
		pin_s2 |=> !pin_low;
	endproperty
	a_pin_filter: assert property (p_pin_filter) else $error("filter passed a high pin");

	property p_wdt_reset;
		@(posedge mclk) disable iff (rst)
		(wdt_overflow && wdt_enable) |=> sys_reset;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("no watchdog reset");

	property p_reset_seq;
		@(posedge mclk)
		any_reset |=> int_disable && wdt_enable && cpu_halt
			&& (port_input == crsc_pkg::PORT_INPUT_ALL);
	endproperty
	a_reset_seq: assert property (p_reset_seq) else $error("reset sequence outputs wrong");

	property p_div_keep;
		@(posedge mclk) disable iff (any_reset)
		(state == crsc_pkg::CRSC_STOP && wake_ok && !bus.wr)
			|=> $stable(system_clock_divider_control);
	endproperty
	a_div_keep: assert property (p_div_keep) else $error("wake changed the divider");

	c_stop: cover property (@(posedge mclk) state == crsc_pkg::CRSC_STOP);
	c_wake: cover property (@(posedge mclk) irq_service);
	c_boot: cover property (@(posedge mclk) pc_load);
	c_lv: cover property (@(posedge mclk) low_voltage_reset_sel && low_voltage && sys_reset);
endmodule : crsc_top

// ---- rtl/crsc_pkg.sv ----
// package: register map, fields, reset values and timing of the clock/reset/stop control
package crsc_pkg;
	// register offsets (stop key and ring osc printed; others chosen locally)
	localparam logic [7:0] OFS_STOP_KEY  = 8'hf8;
	localparam logic [7:0] OFS_RING_OSC  = 8'hff;
	localparam logic [7:0] OFS_OSC_CTRL  = 8'hfb;
	localparam logic [7:0] OFS_CLK_DIV   = 8'hd4;
	localparam logic [7:0] OFS_BT_CTRL   = 8'hd3;
	localparam logic [7:0] OFS_STATUS    = 8'hf0;
	// field positions
	localparam int OSC_SEL_BIT       = 0;
	localparam int OSC_SUB_STOP_BIT  = 2;
	localparam int OSC_MAIN_STOP_BIT = 3;
	localparam int DIV_LO_BIT        = 3;
	localparam int DIV_HI_BIT        = 4;
	localparam int WAKE_EN_BIT       = 7;
	localparam int RING_SEL_BIT      = 6;
	localparam int RING_RUN_BIT      = 7;
	// reset values
	localparam logic [7:0] OSC_CTRL_RST = 8'h00;
	localparam logic [7:0] CLK_DIV_RST  = 8'h80;
	localparam logic [7:0] RING_OSC_RST = 8'h00;
	localparam logic [7:0] STOP_KEY_RST = 8'h00;
	localparam logic [7:0] BT_CTRL_RST  = 8'h00;
	// keys and codes
	localparam logic [7:0] STOP_KEY_VAL = 8'ha5;
	localparam logic [3:0] WDT_OFF_KEY  = 4'ha;
	localparam logic [7:0] STOP_OPCODE  = 8'h7f;
	localparam logic [15:0] RESET_ADDR  = 16'h0100;
	localparam logic [7:0] PORT_INPUT_ALL = 8'h1f;
	// timing
	localparam int MCLK_HZ          = 10_000_000;
	localparam int FILT_NS          = 300;
	localparam int FILT_CYC         = (FILT_NS * (MCLK_HZ / 1_000_000) + 999) / 1000;
	localparam int STAB_CYC_DEFAULT = 4096;

	typedef enum logic [1:0] {
		CRSC_RESET  = 2'b00,
		CRSC_STABLE = 2'b01,
		CRSC_RUN    = 2'b11,
		CRSC_STOP   = 2'b10
	} crsc_state_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} crsc_bus_t;
endpackage : crsc_pkg

// ---- rtl/crsc_clkdiv.sv ----
// glitch-free divider producing a cpu clock enable pulse and an even-duty clock level
`timescale 1ns/1ps
module crsc_clkdiv (
	input  wire logic       mclk,    // block clock
	input  wire logic       rst,     // synchronous reset
	input  wire logic       run,     // source running and not stopped
	input  wire logic [1:0] div_sel, // 00:/16 01:/8 10:/2 11:/1
	output logic            cpu_tick,// one-cycle pulse per cpu clock
	output logic            cpu_clk  // divided clock level
);
	logic [3:0] cnt;
	logic [3:0] cur_limit;
	logic [3:0] next_limit;

	always_comb begin
		case (div_sel)
			2'b00:   next_limit = 4'hf;
			2'b01:   next_limit = 4'h7;
			2'b10:   next_limit = 4'h1;
			default: next_limit = 4'h0;
		endcase
	end

	// divisor is only taken at the end of a whole period, so no phase is ever cut short
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt       <= 4'h0;
			cur_limit <= 4'hf;
			cpu_tick  <= 1'b0;
			cpu_clk   <= 1'b0;
		end else if (run) begin
			if (cnt >= cur_limit) begin
				cnt       <= 4'h0;
				cur_limit <= next_limit;
				cpu_tick  <= 1'b1;
				cpu_clk   <= (next_limit == 4'h0) ? ~cpu_clk : 1'b0;
			end else begin
				cnt      <= cnt + 4'h1;
				cpu_tick <= 1'b0;
				if (cnt == (cur_limit >> 1))
					cpu_clk <= 1'b1;
			end
		end else begin
			cpu_tick <= 1'b0;
		end
	end
endmodule : crsc_clkdiv

// ---- tb/testbench.sv ----
// self-checking bench for the clock source, reset and stop control block
`timescale 1ns/1ps
module testbench;
	// ----------------------------------------
	// setup
	// ----------------------------------------
	localparam int STAB = 16; // short stabilisation wait keeps the run brief
	localparam logic [7:0] A_OSC = crsc_pkg::OFS_OSC_CTRL;
	localparam logic [7:0] A_DIV = crsc_pkg::OFS_CLK_DIV;
	localparam logic [7:0] A_RNG = crsc_pkg::OFS_RING_OSC;
	localparam logic [7:0] A_KEY = crsc_pkg::OFS_STOP_KEY;
	localparam logic [7:0] A_BT  = crsc_pkg::OFS_BT_CTRL;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] rexp;
		logic [4:0] oexp; // main, sub, sel_sub, ring, wake_ring
	} crsc_row_t;
	crsc_row_t rows [11] = '{
		'{A_OSC, 8'h09, 8'h09, 5'b01100}, '{A_OSC, 8'h01, 8'h01, 5'b11100},
		'{A_OSC, 8'hf9, 8'h09, 5'b01100}, '{A_OSC, 8'h01, 8'h01, 5'b11100},
		'{A_OSC, 8'h04, 8'h04, 5'b10000}, '{A_RNG, 8'hff, 8'hc0, 5'b10011},
		'{A_RNG, 8'h40, 8'h40, 5'b10001}, '{A_RNG, 8'h80, 8'h80, 5'b10010},
		'{A_DIV, 8'hff, 8'h98, 5'b10010}, '{8'h10, 8'h55, 8'h00, 5'b10010},
		'{A_KEY, 8'h5a, 8'h5a, 5'b10010}};
	int per [4] = '{16, 8, 2, 1};
	logic                 mclk, rst, external_reset_n, low_voltage_reset_sel, low_voltage;
	logic                 wdt_overflow, opcode_valid, ext_irq_wake, option_addr_use;
	logic [7:0]           opcode, rdata, port_input, d;
	logic [15:0]          option_addr, pc_value;
	logic                 main_osc_en, sub_osc_en, ring_osc_en, wake_tmr_ring, clk_sel_sub;
	logic                 cpu_tick, cpu_clk, sys_reset, cpu_halt, int_disable, wdt_enable;
	logic                 pc_load, irq_service;
	crsc_pkg::crsc_bus_t  bus;
	int                   fails, cmp_count, n, k, h;

	crsc_top #(.STAB_CYC(STAB)) dut_u (.mclk, .rst, .bus, .rdata, .external_reset_n,
		.low_voltage_reset_sel, .low_voltage, .wdt_overflow, .opcode_valid, .opcode, .ext_irq_wake,
		.option_addr, .option_addr_use, .main_osc_en, .sub_osc_en, .ring_osc_en,
		.wake_tmr_ring, .clk_sel_sub, .cpu_tick, .cpu_clk, .sys_reset, .cpu_halt,
		.int_disable, .wdt_enable, .port_input, .pc_load, .pc_value, .irq_service);

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	task automatic tk(input int c);
		repeat (c) @(posedge mclk);
	endtask : tk
	// the idle cycle after a write keeps the strobe from being driven twice in one step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge mclk);
		bus <= '0;
		@(posedge mclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge mclk);
		bus <= '0;
		@(posedge mclk);
		v = rdata;
	endtask : rd
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
		end
	endtask : chk
	task automatic boot(input logic [15:0] pc);
		int i;
		for (i = 0; i < STAB + 40 && pc_load !== 1'b1; i++) @(posedge mclk);
		chk(pc_load, 1'b1);
		chk(16'(i >= STAB), 16'h0001);
		chk(pc_value, pc);
		tk(3);
		chk(cpu_halt, 1'b0);
	endtask : boot
	task automatic hit_rst;
		int i;
		for (i = 0; i < 12 && sys_reset !== 1'b1; i++) @(posedge mclk);
		chk(sys_reset, 1'b1);
	endtask : hit_rst
	task automatic op(input logic [7:0] c);
		opcode_valid <= 1'b1;
		opcode <= c;
		@(posedge mclk);
		opcode_valid <= 1'b0;
		tk(3);
	endtask : op
	task automatic meas(output int g);
		int i;
		for (i = 0; i < 40 && cpu_tick !== 1'b1; i++) @(posedge mclk);
		g = 0;
		do begin
			@(posedge mclk);
			g++;
		end while (cpu_tick !== 1'b1 && g < 40);
	endtask : meas
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : close_out

	initial begin
		tk(5000);
		fails++;
		close_out();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		{bus, wdt_overflow, opcode_valid, opcode, ext_irq_wake, option_addr_use} = '0;
		{low_voltage_reset_sel, low_voltage} = 2'b00;
		external_reset_n = 1'b1;
		option_addr = 16'h1234;
		rst = 1'b1;
		fails = 0;
		cmp_count = 0;
		tk(16);
		chk(sys_reset, 1'b1);
		chk(cpu_halt, 1'b1);
		chk(int_disable, 1'b1);
		chk(wdt_enable, 1'b1);
		chk(port_input, 8'h1f);
		chk(pc_value, 16'h0100);
		rst <= 1'b0;
		boot(16'h0100);
		rd(A_OSC, d);
		chk(d, 8'h00);
		rd(A_DIV, d);
		chk(d, 8'h80);
		rd(A_RNG, d);
		chk(d, 8'h00);
		rd(A_KEY, d);
		chk(d, 8'h00);
		chk({main_osc_en, sub_osc_en, clk_sel_sub, ring_osc_en, wake_tmr_ring}, 5'b11000);
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, d);
			chk(d, rows[i].rexp);
			chk({main_osc_en, sub_osc_en, clk_sel_sub, ring_osc_en, wake_tmr_ring}, rows[i].oexp);
		end
		for (k = 0; k < 4; k++) begin
			wr(A_DIV, {3'b100, 2'(k), 3'b000});
			tk(40);
			meas(n);
			chk(16'(n), 16'(per[k]));
			// every divisor keeps half duty, so any 16-cycle window holds 8 high cycles
			h = 0;
			repeat (16) begin
				@(posedge mclk);
				h += int'(cpu_clk);
			end
			chk(16'(h), 16'h0008);
		end
		op(8'h7f);
		chk(cpu_halt, 1'b0);
		chk(main_osc_en, 1'b1);
		wr(A_BT, 8'h00);
		wr(A_KEY, 8'ha5);
		op(8'h6f);
		chk(cpu_halt, 1'b0);
		op(8'h7f);
		chk(cpu_halt, 1'b1);
		chk(main_osc_en, 1'b0);
		ext_irq_wake <= 1'b1;
		@(posedge mclk);
		ext_irq_wake <= 1'b0;
		for (k = 0; k < STAB + 40 && irq_service !== 1'b1; k++) @(posedge mclk);
		chk(irq_service, 1'b1);
		tk(3);
		chk(cpu_halt, 1'b0);
		chk(main_osc_en, 1'b1);
		rd(A_DIV, d);
		chk(d, 8'h98);
		rd(A_OSC, d);
		chk(d, 8'h04);
		op(8'h7f);
		chk(cpu_halt, 1'b1);
		external_reset_n <= 1'b0;
		hit_rst();
		tk(10);
		external_reset_n <= 1'b1;
		boot(16'h0100);
		rd(A_DIV, d);
		chk(d, 8'h80);
		rd(A_KEY, d);
		chk(d, 8'h00);
		// a one-cycle dip on the pin must be swallowed by the filter
		external_reset_n <= 1'b0;
		@(posedge mclk);
		external_reset_n <= 1'b1;
		tk(10);
		chk(cpu_halt, 1'b0);
		low_voltage_reset_sel <= 1'b1;
		@(posedge mclk);
		external_reset_n <= 1'b0;
		tk(12);
		chk(cpu_halt, 1'b0);
		external_reset_n <= 1'b1;
		low_voltage <= 1'b1;
		option_addr_use <= 1'b1;
		hit_rst();
		tk(30);
		chk(sys_reset, 1'b1);
		low_voltage <= 1'b0;
		boot(16'h1234);
		option_addr_use <= 1'b0;
		low_voltage_reset_sel <= 1'b0;
		@(posedge mclk);
		low_voltage <= 1'b1;
		tk(10);
		chk(cpu_halt, 1'b0);
		low_voltage <= 1'b0;
		chk(wdt_enable, 1'b1);
		wdt_overflow <= 1'b1;
		@(posedge mclk);
		wdt_overflow <= 1'b0;
		hit_rst();
		boot(16'h0100);
		wr(A_BT, 8'ha0);
		tk(2);
		chk(wdt_enable, 1'b0);
		wdt_overflow <= 1'b1;
		@(posedge mclk);
		wdt_overflow <= 1'b0;
		tk(10);
		chk(cpu_halt, 1'b0);
		wr(A_BT, 8'h50);
		tk(2);
		chk(wdt_enable, 1'b1);
		close_out();
	end
endmodule : testbench
